// ### pie_pkg.sv
// constants for the pci port interrupt enable block
package pie_pkg;

   // ==========================================================
   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_PENDING = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_RAW = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h00C;

   // ==========================================================
   // enable register field positions
   localparam int unsigned BIT_POWER_STATE = 0;
   localparam int unsigned BIT_TARGET_ABORT = 1;
   localparam int unsigned BIT_MASTER_ABORT = 2;
   localparam int unsigned BIT_HOST_REQUEST = 3;
   localparam int unsigned BIT_WAKE_RISE = 4;
   localparam int unsigned BIT_WAKE_FALL = 5;
   localparam int unsigned BIT_MASTER_DONE = 6;
   localparam int unsigned BIT_CONFIG_COMPLETE = 7;
   localparam int unsigned BIT_CONFIG_ERROR = 8;
   localparam int unsigned BIT_EEPROM_READY = 9;
   localparam int unsigned BIT_RSVD_LOW = 10;
   localparam int unsigned BIT_PCI_RESET = 11;
   localparam int unsigned BIT_RSVD_HIGH = 12;

   // ==========================================================
   // enable register masks and reset value
   localparam logic [DATA_W-1:0] ENABLE_IMPL_MASK = 32'h0000_0BFF;
   localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0008;

   // ==========================================================
   // control register fields
   localparam int unsigned BIT_CTRL_IRQ_GATE = 0;
   localparam int unsigned BIT_CTRL_WARM = 1;
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0001;

   // no wait states: a transfer ends in its first access cycle
   localparam int unsigned APB_WAIT_CYCLES = 0;

endpackage

// ### pie_enable_reg.sv
// storage of the interrupt enable bits with write mask and reset value
module pie_enable_reg
   import pie_pkg::*;
#(
   parameter logic [DATA_W-1:0] IMPL_MASK = ENABLE_IMPL_MASK,
   parameter logic [DATA_W-1:0] RESET_VALUE = ENABLE_RESET
) (
   // clocking
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // reset request from the warm reset sources
   input wire logic warm,
   // software write
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   // stored value
   output logic [DATA_W-1:0] q
);

   logic [DATA_W-1:0] q_r;
   logic [DATA_W-1:0] q_nxt;

   // ==========================================================
   // next value
   always_comb begin
      q_nxt = q_r;
      if (warm) begin
         q_nxt = RESET_VALUE & IMPL_MASK;
      end else if (wr_en) begin
         // unimplemented and reserved positions never store anything
         q_nxt = wr_data & IMPL_MASK;
      end
   end

   // ==========================================================
   // register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         q_r <= RESET_VALUE & IMPL_MASK;
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

endmodule

// ### pie_top.sv
// apb register block holding the pci port interrupt enables and the request gate
//
// What this block does
// - bits 31 to 13 of the enable register read as zero and writes to them are dropped.
// - bit 11 passes pci reset transition interrupts only while it is one, reset zero.
// - bit 9 passes the eeprom ready interrupt only while it is one, reset zero.
// - bit 8 passes the configuration checksum error interrupt only while one, reset zero.
// - bit 7 passes the configuration complete interrupt only while one, reset zero.
// - bit 6 passes the master transaction done interrupt only while one, reset zero.
// - every implemented enable returns to its reset value on device reset and warm reset.
// - after reset only the host software request enable, bit 3, is one.
// - bits 5 and 4 enable the falling and rising wake output edge interrupts, reset zero.
// - bits 2 and 1 enable the master abort and target abort interrupts, reset zero.
// - bit 0 enables the power management state change interrupt, reset zero.
//
// Our own choices: register access over APB and the placing of the registers.
module pie_top
   import pie_pkg::*;
#(
   parameter int unsigned SRC_W = 12
) (
   // clocking and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic core_ce,
   // warm reset of the pci port, one cycle or longer
   input wire logic warm_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt sources, level, one bit per enable position
   input wire logic [SRC_W-1:0] source_status,
   // request towards the processor
   output logic pci_irq_req
);

   // ==========================================================
   // declarations
   logic [DATA_W-1:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic pci_irq_req_r;
   logic [DATA_W-1:0] ctrl_r;
   logic [DATA_W-1:0] enable_q;
   logic [DATA_W-1:0] status_w;
   logic [DATA_W-1:0] pending_w;
   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic enable_wr;
   logic ctrl_wr;
   logic sw_warm;
   logic warm_any;
   logic mapped;
   logic [DATA_W-1:0] rd_value;

   // ==========================================================
   // helpers
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = (a == OFS_ENABLE) || (a == OFS_PENDING) ||
                    (a == OFS_RAW) || (a == OFS_CTRL);
   endfunction

   function automatic logic [DATA_W-1:0] widen_src(input logic [SRC_W-1:0] s);
      logic [DATA_W-1:0] w;
      w = '0;
      w[SRC_W-1:0] = s;
      widen_src = w;
   endfunction

   // ==========================================================
   // apb phase decode
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready_r;
   assign wr_done = access_done && pwrite && !pslverr_r;
   assign enable_wr = wr_done && (paddr == OFS_ENABLE);
   assign ctrl_wr = wr_done && (paddr == OFS_CTRL);
   assign mapped = addr_mapped(paddr);

   // a warm reset requested by software takes effect with the write itself
   assign sw_warm = ctrl_wr && pwdata[BIT_CTRL_WARM];
   assign warm_any = warm_rst || sw_warm;

   // ==========================================================
   // enable storage
   pie_enable_reg #(
      .IMPL_MASK(ENABLE_IMPL_MASK),
      .RESET_VALUE(ENABLE_RESET)
   ) u_enable (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(core_ce),
      .warm(warm_any),
      .wr_en(enable_wr),
      .wr_data(pwdata),
      .q(enable_q)
   );

   // ==========================================================
   // per source gating
   // reserved positions of the source word are forced low so a stray
   // source line can never raise a request through an empty slot
   assign status_w = widen_src(source_status) & ENABLE_IMPL_MASK;

   always_comb begin
      pending_w = '0;
      pending_w[BIT_PCI_RESET] =
         status_w[BIT_PCI_RESET] & enable_q[BIT_PCI_RESET];
      pending_w[BIT_EEPROM_READY] =
         status_w[BIT_EEPROM_READY] & enable_q[BIT_EEPROM_READY];
      pending_w[BIT_CONFIG_ERROR] =
         status_w[BIT_CONFIG_ERROR] & enable_q[BIT_CONFIG_ERROR];
      pending_w[BIT_CONFIG_COMPLETE] =
         status_w[BIT_CONFIG_COMPLETE] & enable_q[BIT_CONFIG_COMPLETE];
      pending_w[BIT_MASTER_DONE] =
         status_w[BIT_MASTER_DONE] & enable_q[BIT_MASTER_DONE];
      pending_w[BIT_WAKE_FALL] =
         status_w[BIT_WAKE_FALL] & enable_q[BIT_WAKE_FALL];
      pending_w[BIT_WAKE_RISE] =
         status_w[BIT_WAKE_RISE] & enable_q[BIT_WAKE_RISE];
      pending_w[BIT_HOST_REQUEST] =
         status_w[BIT_HOST_REQUEST] & enable_q[BIT_HOST_REQUEST];
      pending_w[BIT_MASTER_ABORT] =
         status_w[BIT_MASTER_ABORT] & enable_q[BIT_MASTER_ABORT];
      pending_w[BIT_TARGET_ABORT] =
         status_w[BIT_TARGET_ABORT] & enable_q[BIT_TARGET_ABORT];
      pending_w[BIT_POWER_STATE] =
         status_w[BIT_POWER_STATE] & enable_q[BIT_POWER_STATE];
   end

   // ==========================================================
   // control register
   // only the gate bit is stored; the warm bit is a write-only strobe
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_r <= CTRL_RESET;
      end else if (core_ce) begin
         if (ctrl_wr) begin
            ctrl_r <= '0;
            ctrl_r[BIT_CTRL_IRQ_GATE] <= pwdata[BIT_CTRL_IRQ_GATE];
         end
      end
   end

   // ==========================================================
   // interrupt request
   // registered, so the request trails a source or enable change by one cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pci_irq_req_r <= 1'b0;
      end else if (core_ce) begin
         pci_irq_req_r <= (|pending_w) && ctrl_r[BIT_CTRL_IRQ_GATE];
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      rd_value = '0;
      unique case (paddr)
         OFS_ENABLE: rd_value = enable_q & ENABLE_IMPL_MASK;
         OFS_PENDING: rd_value = pending_w;
         OFS_RAW: rd_value = status_w;
         OFS_CTRL: rd_value = ctrl_r;
         default: rd_value = '0;
      endcase
   end

   // ==========================================================
   // apb response
   // the answer is prepared in the setup cycle, so with core_ce high in that cycle every access phase
   // lasts exactly one cycle and back-to-back transfers run at full rate
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (core_ce) begin
         pready_r <= setup_phase;
         pslverr_r <= setup_phase && !mapped;
      end
   end

   // read data sampled at the setup edge; a write in the same access cannot
   // reach it because the register only changes at the end of the access
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata_r <= '0;
      end else if (core_ce) begin
         if (setup_phase && !pwrite) begin
            prdata_r <= rd_value;
         end else if (access_done) begin
            prdata_r <= '0;
         end
      end
   end

   // ==========================================================
   // outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pci_irq_req = pci_irq_req_r;

endmodule

// ### pie_top_sva.sv
// port checker for the pci interrupt enable block
module pie_top_chk
   import pie_pkg::*;
#(
   parameter int unsigned SRC_W = 12
) (
   // clocking and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic core_ce,
   input wire logic warm_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // interrupt side
   input wire logic [SRC_W-1:0] source_status,
   input wire logic pci_irq_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_ready_after_setup: assert property (psel && !penable && core_ce |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready && core_ce |=> !pready)
      else $error("ready longer than a cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_idle_data_zero: assert property (!pready |-> prdata == '0)
      else $error("read data outside access");
   a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
      12'h008, 12'h00C}))
      else $error("wrong error response");
   a_reserved_read: assert property (pready && !pwrite && paddr == OFS_ENABLE
      |-> (prdata & ~ENABLE_IMPL_MASK) == '0)
      else $error("reserved enable bits read nonzero");
   a_irq_cause: assert property (pci_irq_req |-> $past(source_status) != '0)
      else $error("request without any source");
   a_reset_quiet: assert property (disable iff (1'b0) !nrst && core_ce
      |=> !pready && prdata == '0 && !pci_irq_req)
      else $error("outputs active in reset");
   a_host_wake: assert property (disable iff (1'b0) !nrst ##1 nrst && !psel && !warm_rst
      && source_status == 12'h008 |=> pci_irq_req)
      else $error("host request not enabled after reset");
   // ==========================================================
   // coverage
   c_write: cover property (pready && pwrite);
   c_error: cover property (pready && pslverr);
   c_irq: cover property ($rose(pci_irq_req));
endmodule

bind pie_top pie_top_chk #(.SRC_W(SRC_W)) i_chk (.core_clk(core_clk), .nrst(nrst),
   .core_ce(core_ce), .warm_rst(warm_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .source_status(source_status), .pci_irq_req(pci_irq_req));

// ### pci_port_interrupt_enable_bench.sv
// self-checking bench for the pci interrupt enable block
module pci_port_interrupt_enable_bench
   import pie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // design hookup
   logic core_clk, nrst, core_ce, warm_rst, psel, penable, pwrite, pready, pslverr, pci_irq_req;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [11:0] source_status;
   int fail_count, n_tests;
   pie_top i_dut (.core_clk(core_clk), .nrst(nrst), .core_ce(core_ce), .warm_rst(warm_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .source_status(source_status),
      .pci_irq_req(pci_irq_req));
   always #50 core_clk = ~core_clk;
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // entered just after an edge; the idle cycle at the end keeps psel from toggling twice
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // no cycle count is assumed here: a slave that never answers is left to the watchdog
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic ee);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, {31'h0, ee});
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, 32'h0);
   endtask
   // request is one cycle behind the sources
   task automatic src(input logic [11:0] s, input logic x);
      source_status <= s;
      repeat (2) @(posedge core_clk);
      chk({31'h0, pci_irq_req}, {31'h0, x});
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(OFS_ENABLE, 32'h0000_0008);
      src(12'h008, 1'b1);
      src(12'h000, 1'b0);
      $display("reset values done");
   endtask
   task automatic t_bits;
      for (int b = 0; b < 12; b++) begin
         // reserved bits 12 and 10 are only ever written with zero
         wr(OFS_ENABLE, (32'h1 << b) & ~32'h0000_1400, 1'b0);
         rd(OFS_ENABLE, (32'h1 << b) & ENABLE_IMPL_MASK);
         src(12'hFFF & ~(12'h1 << b), 1'b0);
         src(12'h1 << b, ENABLE_IMPL_MASK[b]);
      end
      wr(OFS_ENABLE, 32'hFFFF_EBFF, 1'b0);
      rd(OFS_ENABLE, 32'h0000_0BFF);
      src(12'hFFF, 1'b1);
      rd(OFS_PENDING, 32'h0000_0BFF);
      rd(OFS_RAW, 32'h0000_0BFF);
      wr(OFS_PENDING, 32'h0, 1'b0);
      rd(OFS_ENABLE, 32'h0000_0BFF);
      $display("enable bits done");
   endtask
   task automatic t_warm;
      warm_rst <= 1'b1;
      @(posedge core_clk);
      warm_rst <= 1'b0;
      @(posedge core_clk);
      rd(OFS_ENABLE, 32'h0000_0008);
      wr(OFS_ENABLE, 32'h0000_00F0, 1'b0);
      wr(OFS_CTRL, 32'h0000_0003, 1'b0);
      rd(OFS_CTRL, 32'h0000_0001);
      rd(OFS_ENABLE, 32'h0000_0008);
      wr(12'h010, 32'h0000_0BFF, 1'b1);
      rd(OFS_ENABLE, 32'h0000_0008);
      $display("warm reset done");
   endtask
   // the request must hold its old value while the clock enable is low
   task automatic t_ce;
      src(12'h000, 1'b0);
      core_ce <= 1'b0;
      src(12'h008, 1'b0);
      core_ce <= 1'b1;
      src(12'h008, 1'b1);
      $display("clock enable done");
   endtask
   task automatic t_rst2;
      wr(OFS_ENABLE, 32'h0000_0BF7, 1'b0);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(OFS_ENABLE, 32'h0000_0008);
      src(12'h008, 1'b1);
      $display("second reset done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      core_ce = 1'b1;
      warm_rst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      source_status = 12'h008;
      fail_count = 0;
      n_tests = 0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_bits();
      t_warm();
      t_ce();
      t_rst2();
      end_of_test();
   end
   initial begin
      #1_000_000;
      fail_count++;
      end_of_test();
   end
endmodule
